// File: ufc_top.sv
// Operation
// - An eight-bit read/write format register holds stop count, parity polarity, parity on, loopback, protocol and length code, all zero after reset.
// - Transmit appends one stop bit when the stop count is 0 and two when it is 1.
// - The receiver checks only the first stop bit of each frame.
// - With parity on, polarity 0 gives odd and 1 gives even parity over the one bits of the character.
// - Parity on at 0 means no parity bit is sent and none is expected.
// - In address-bit protocol the address bit takes part in the parity on both directions.
// - Data bit positions beyond the character length stay out of the parity.
// - Loopback at 1 feeds the transmit output to the receive input internally.
`timescale 1ns/10ps
`default_nettype none
module ufc_top
  import ufc_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_arst_n,
  input wire logic [ufc_pkg::ADDR_W-1:0] i_s_axi_awaddr,
  input wire logic i_s_axi_awvalid,
  output logic o_s_axi_awready,
  input wire logic [31:0] i_s_axi_wdata,
  input wire logic [3:0] i_s_axi_wstrb,
  input wire logic i_s_axi_wvalid,
  output logic o_s_axi_wready,
  output logic [1:0] o_s_axi_bresp,
  output logic o_s_axi_bvalid,
  input wire logic i_s_axi_bready,
  input wire logic [ufc_pkg::ADDR_W-1:0] i_s_axi_araddr,
  input wire logic i_s_axi_arvalid,
  output logic o_s_axi_arready,
  output logic [31:0] o_s_axi_rdata,
  output logic [1:0] o_s_axi_rresp,
  output logic o_s_axi_rvalid,
  input wire logic i_s_axi_rready,
  input wire logic i_rxd,
  output logic o_txd
);
  import ufc_pkg::*;

  // ***************************************************************
  // register addresses
  // ***************************************************************
  localparam logic [ADDR_W-1:0] A_FMT = {IDX_FMT, 2'b00};
  localparam logic [ADDR_W-1:0] A_DIV = {IDX_DIV, 2'b00};
  localparam logic [ADDR_W-1:0] A_TXD = {IDX_TXD, 2'b00};
  localparam logic [ADDR_W-1:0] A_RXD = {IDX_RXD, 2'b00};
  localparam logic [ADDR_W-1:0] A_STAT = {IDX_STAT, 2'b00};

  logic [7:0] frame_format_control;
  logic [15:0] baud_divisor;
  logic [7:0] tx_data;
  logic tx_addr_bit;
  logic tx_start;
  logic tx_busy;
  logic tx_line;
  logic rx_ready;
  logic par_err;
  logic frm_err;
  logic [7:0] rx_data;
  logic rx_addr_bit;
  logic rx_par_err;
  logic rx_frm_err;
  logic rx_done;
  logic [2:0] rxd_sync;
  logic rxd_clean;
  logic rx_line;
  logic [15:0] div_cnt;
  logic baud_tick;
  logic wr_go;
  logic rd_go;
  logic [ADDR_W-1:0] wr_addr;
  logic [ADDR_W-1:0] rd_addr;
  logic wr_hit;
  logic rd_hit;
  logic rd_rxd;
  logic clr_stat;
  logic [31:0] next_rdata;

  // ***************************************************************
  // receive pin synchroniser and loopback
  // ***************************************************************
  always_ff @(posedge i_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
      rxd_sync <= 3'h7;
    else
      rxd_sync <= {rxd_sync[1:0], i_rxd};
  end

  // a level counts only once the second and third stage agree
  always_ff @(posedge i_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
      rxd_clean <= 1'b1;
    else if (rxd_sync[1] == rxd_sync[2])
      rxd_clean <= rxd_sync[2];
  end

  // in loopback the pin idles high so the far end sees no traffic
  assign rx_line = frame_format_control[FMT_LOOP] ? tx_line : rxd_clean;

  always_ff @(posedge i_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
      o_txd <= 1'b1;
    else
      o_txd <= frame_format_control[FMT_LOOP] ? 1'b1 : tx_line;
  end

  // ***************************************************************
  // baud tick, sixteen per bit
  // ***************************************************************
  always_ff @(posedge i_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      div_cnt <= 16'h0000;
      baud_tick <= 1'b0;
    end
    else if (div_cnt >= baud_divisor)
    begin
      div_cnt <= 16'h0000;
      baud_tick <= 1'b1;
    end
    else
    begin
      div_cnt <= div_cnt + 16'h0001;
      baud_tick <= 1'b0;
    end
  end

  // ***************************************************************
  // axi4-lite write channel
  // ***************************************************************
  // address and data are taken together; a lone one waits for its partner
  assign wr_go = i_s_axi_awvalid && i_s_axi_wvalid && !o_s_axi_bvalid;
  assign o_s_axi_awready = wr_go;
  assign o_s_axi_wready = wr_go;
  assign wr_addr = {i_s_axi_awaddr[ADDR_W-1:2], 2'b00};
  assign wr_hit = (wr_addr == A_FMT) || (wr_addr == A_DIV) || (wr_addr == A_TXD)
                  || (wr_addr == A_RXD) || (wr_addr == A_STAT);

  always_ff @(posedge i_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      o_s_axi_bvalid <= 1'b0;
      o_s_axi_bresp <= RESP_OKAY;
    end
    else if (wr_go)
    begin
      o_s_axi_bvalid <= 1'b1;
      o_s_axi_bresp <= wr_hit ? RESP_OKAY : RESP_SLVERR;
    end
    else if (i_s_axi_bready)
      o_s_axi_bvalid <= 1'b0;
  end

  always_ff @(posedge i_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
      frame_format_control <= FMT_RST;
    else if (wr_go && wr_addr == A_FMT && i_s_axi_wstrb[0])
      frame_format_control <= i_s_axi_wdata[7:0];
  end

  always_ff @(posedge i_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
      baud_divisor <= DIV_RST;
    else if (wr_go && wr_addr == A_DIV)
    begin
      if (i_s_axi_wstrb[0])
        baud_divisor[7:0] <= i_s_axi_wdata[7:0];
      if (i_s_axi_wstrb[1])
        baud_divisor[15:8] <= i_s_axi_wdata[15:8];
    end
  end

  // a write while the transmitter is busy is dropped; software polls busy
  always_ff @(posedge i_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      tx_data <= 8'h00;
      tx_addr_bit <= 1'b0;
      tx_start <= 1'b0;
    end
    else
    begin
      tx_start <= 1'b0;
      if (wr_go && wr_addr == A_TXD && i_s_axi_wstrb[0] && !tx_busy && !tx_start)
      begin
        tx_data <= i_s_axi_wdata[7:0];
        tx_addr_bit <= i_s_axi_wstrb[1] & i_s_axi_wdata[TXD_ADDR_BIT];
        tx_start <= 1'b1;
      end
    end
  end

  // ***************************************************************
  // axi4-lite read channel
  // ***************************************************************
  assign rd_go = i_s_axi_arvalid && !o_s_axi_rvalid;
  assign o_s_axi_arready = rd_go;
  assign rd_addr = {i_s_axi_araddr[ADDR_W-1:2], 2'b00};
  assign rd_rxd = rd_go && (rd_addr == A_RXD);
  assign clr_stat = wr_go && (wr_addr == A_STAT) && i_s_axi_wstrb[0];

  always_comb
  begin
    next_rdata = 32'h0000_0000;
    rd_hit = 1'b1;
    case (rd_addr)
      A_FMT: next_rdata[7:0] = frame_format_control;
      A_DIV: next_rdata[15:0] = baud_divisor;
      A_TXD: next_rdata[8:0] = {tx_addr_bit, tx_data};
      A_RXD: next_rdata[8:0] = {rx_addr_bit, rx_data};
      A_STAT:
      begin
        next_rdata[ST_TX_BUSY] = tx_busy || tx_start;
        next_rdata[ST_RX_READY] = rx_ready;
        next_rdata[ST_PAR_ERR] = par_err;
        next_rdata[ST_FRM_ERR] = frm_err;
      end
      default: rd_hit = 1'b0;
    endcase
  end

  always_ff @(posedge i_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      o_s_axi_rvalid <= 1'b0;
      o_s_axi_rdata <= 32'h0000_0000;
      o_s_axi_rresp <= RESP_OKAY;
    end
    else if (rd_go)
    begin
      o_s_axi_rvalid <= 1'b1;
      o_s_axi_rdata <= next_rdata;
      o_s_axi_rresp <= rd_hit ? RESP_OKAY : RESP_SLVERR;
    end
    else if (i_s_axi_rready)
      o_s_axi_rvalid <= 1'b0;
  end

  // ***************************************************************
  // sticky status: a new event beats a clear in the same cycle
  // ***************************************************************
  always_ff @(posedge i_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
      rx_ready <= 1'b0;
    else if (rx_done)
      rx_ready <= 1'b1;
    else if (rd_rxd)
      rx_ready <= 1'b0;
  end

  always_ff @(posedge i_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      par_err <= 1'b0;
      frm_err <= 1'b0;
    end
    else
    begin
      if (rx_done && rx_par_err)
        par_err <= 1'b1;
      else if (clr_stat && i_s_axi_wdata[ST_PAR_ERR])
        par_err <= 1'b0;
      if (rx_done && rx_frm_err)
        frm_err <= 1'b1;
      else if (clr_stat && i_s_axi_wdata[ST_FRM_ERR])
        frm_err <= 1'b0;
    end
  end

  // ***************************************************************
  // shifters
  // ***************************************************************
  ufc_tx u_tx (
    .i_clk(i_clk),
    .i_arst_n(i_arst_n),
    .i_tick(baud_tick),
    .i_start(tx_start),
    .i_data(tx_data),
    .i_addr_bit(tx_addr_bit),
    .i_fmt(frame_format_control),
    .o_busy(tx_busy),
    .o_txd(tx_line)
  );

  ufc_rx u_rx (
    .i_clk(i_clk),
    .i_arst_n(i_arst_n),
    .i_tick(baud_tick),
    .i_line(rx_line),
    .i_fmt(frame_format_control),
    .o_data(rx_data),
    .o_addr_bit(rx_addr_bit),
    .o_par_err(rx_par_err),
    .o_frm_err(rx_frm_err),
    .o_done(rx_done)
  );
endmodule : ufc_top
`default_nettype wire

// File: ufc_pkg.sv
package ufc_pkg;

  // ***************************************************************
  // register map (word indices, byte address is index times four)
  // ***************************************************************
  localparam int unsigned ADDR_W = 17;
  localparam logic [14:0] IDX_FMT = 15'h7050;
  localparam logic [14:0] IDX_DIV = 15'h7051;
  localparam logic [14:0] IDX_TXD = 15'h7052;
  localparam logic [14:0] IDX_RXD = 15'h7053;
  localparam logic [14:0] IDX_STAT = 15'h7054;

  // ***************************************************************
  // fields and reset values
  // ***************************************************************
  localparam int unsigned FMT_STOP2 = 7;
  localparam int unsigned FMT_EVEN = 6;
  localparam int unsigned FMT_PAR_ON = 5;
  localparam int unsigned FMT_LOOP = 4;
  localparam int unsigned FMT_ADDR_MODE = 3;
  localparam int unsigned FMT_LEN_HI = 2;
  localparam logic [7:0] FMT_RST = 8'h00;
  localparam logic [15:0] DIV_RST = 16'h0043;
  localparam int unsigned TXD_ADDR_BIT = 8;
  localparam int unsigned ST_TX_BUSY = 0;
  localparam int unsigned ST_RX_READY = 1;
  localparam int unsigned ST_PAR_ERR = 2;
  localparam int unsigned ST_FRM_ERR = 3;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ***************************************************************
  // timing: sixteen baud ticks per bit
  // ***************************************************************
  localparam logic [3:0] TICK_MID = 4'h7;
  localparam logic [3:0] TICK_LAST = 4'hf;

  typedef enum logic [2:0] {ST_IDLE, ST_START, ST_DATA, ST_ADDR, ST_PAR, ST_STOP} ufc_bit_type;

  // parity over the live data bits, plus the address bit in address-bit mode
  function automatic logic ufc_parity(input logic [7:0] data, input logic [7:0] fmt,
                                      input logic addr_bit);
    logic acc;
    acc = 1'b0;
    for (int i = 0; i < 8; i++)
    begin
      if (3'(i) <= fmt[FMT_LEN_HI:0])
        acc = acc ^ data[i];
    end
    if (fmt[FMT_ADDR_MODE])
      acc = acc ^ addr_bit;
    ufc_parity = acc ^ ~fmt[FMT_EVEN];
  endfunction : ufc_parity

endpackage : ufc_pkg

// File: ufc_tx.sv
`timescale 1ns/10ps
`default_nettype none
module ufc_tx
  import ufc_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_arst_n,
  input wire logic i_tick,
  input wire logic i_start,
  input wire logic [7:0] i_data,
  input wire logic i_addr_bit,
  input wire logic [7:0] i_fmt,
  output logic o_busy,
  output logic o_txd
);
  ufc_bit_type state;
  logic [3:0] tick_cnt;
  logic [2:0] bit_cnt;
  logic [7:0] data;
  logic [7:0] fmt;
  logic addr_bit;
  logic second_stop;
  logic next_txd;
  logic bit_end;

  assign bit_end = i_tick && (tick_cnt == TICK_LAST);
  assign o_busy = (state != ST_IDLE);

  // format is latched per frame so a register write never tears a character
  always_ff @(posedge i_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      state <= ST_IDLE;
      tick_cnt <= 4'h0;
      bit_cnt <= 3'h0;
      data <= 8'h00;
      fmt <= 8'h00;
      addr_bit <= 1'b0;
      second_stop <= 1'b0;
    end
    else if (state == ST_IDLE)
    begin
      tick_cnt <= 4'h0;
      bit_cnt <= 3'h0;
      second_stop <= 1'b0;
      if (i_start)
      begin
        state <= ST_START;
        data <= i_data;
        fmt <= i_fmt;
        addr_bit <= i_addr_bit;
      end
    end
    else if (i_tick)
    begin
      tick_cnt <= tick_cnt + 4'h1;
      if (bit_end)
      begin
        case (state)
          ST_START: state <= ST_DATA;
          ST_DATA:
          begin
            bit_cnt <= bit_cnt + 3'h1;
            if (bit_cnt == fmt[FMT_LEN_HI:0])
              state <= fmt[FMT_ADDR_MODE] ? ST_ADDR
                     : (fmt[FMT_PAR_ON] ? ST_PAR : ST_STOP);
          end
          ST_ADDR: state <= fmt[FMT_PAR_ON] ? ST_PAR : ST_STOP;
          ST_PAR: state <= ST_STOP;
          ST_STOP:
          begin
            if (fmt[FMT_STOP2] && !second_stop)
              second_stop <= 1'b1;
            else
              state <= ST_IDLE;
          end
          default: state <= ST_IDLE;
        endcase
      end
    end
  end

  always_comb
  begin
    case (state)
      ST_START: next_txd = 1'b0;
      ST_DATA: next_txd = data[bit_cnt];
      ST_ADDR: next_txd = addr_bit;
      ST_PAR: next_txd = ufc_parity(data, fmt, addr_bit);
      default: next_txd = 1'b1;
    endcase
  end

  always_ff @(posedge i_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
      o_txd <= 1'b1;
    else
      o_txd <= next_txd;
  end
endmodule : ufc_tx
`default_nettype wire

// File: ufc_rx.sv
`timescale 1ns/10ps
`default_nettype none
module ufc_rx
  import ufc_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_arst_n,
  input wire logic i_tick,
  input wire logic i_line,
  input wire logic [7:0] i_fmt,
  output logic [7:0] o_data,
  output logic o_addr_bit,
  output logic o_par_err,
  output logic o_frm_err,
  output logic o_done
);
  ufc_bit_type state;
  logic [3:0] tick_cnt;
  logic [2:0] bit_cnt;
  logic [7:0] fmt;
  logic sample;

  assign sample = i_tick && (tick_cnt == TICK_LAST);

  always_ff @(posedge i_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      state <= ST_IDLE;
      tick_cnt <= 4'h0;
      bit_cnt <= 3'h0;
      fmt <= 8'h00;
      o_data <= 8'h00;
      o_addr_bit <= 1'b0;
      o_par_err <= 1'b0;
      o_frm_err <= 1'b0;
      o_done <= 1'b0;
    end
    else
    begin
      o_done <= 1'b0;
      case (state)
        ST_IDLE:
        begin
          tick_cnt <= 4'h0;
          bit_cnt <= 3'h0;
          if (!i_line)
          begin
            state <= ST_START;
            fmt <= i_fmt;
            o_data <= 8'h00;
            o_addr_bit <= 1'b0;
          end
        end
        ST_START:
        begin
          if (i_tick)
          begin
            tick_cnt <= tick_cnt + 4'h1;
            if (tick_cnt == TICK_MID)
            begin
              tick_cnt <= 4'h0;
              state <= i_line ? ST_IDLE : ST_DATA;
            end
          end
        end
        default:
        begin
          if (i_tick)
            tick_cnt <= tick_cnt + 4'h1;
          if (sample)
          begin
            case (state)
              ST_DATA:
              begin
                o_data[bit_cnt] <= i_line;
                bit_cnt <= bit_cnt + 3'h1;
                if (bit_cnt == fmt[FMT_LEN_HI:0])
                  state <= fmt[FMT_ADDR_MODE] ? ST_ADDR
                         : (fmt[FMT_PAR_ON] ? ST_PAR : ST_STOP);
              end
              ST_ADDR:
              begin
                o_addr_bit <= i_line;
                state <= fmt[FMT_PAR_ON] ? ST_PAR : ST_STOP;
              end
              ST_PAR:
              begin
                o_par_err <= (i_line != ufc_parity(o_data, fmt, o_addr_bit));
                state <= ST_STOP;
              end
              ST_STOP:
              begin
                // only the first stop bit is looked at, whatever the setting
                o_frm_err <= !i_line;
                o_done <= 1'b1;
                state <= ST_IDLE;
              end
              default: state <= ST_IDLE;
            endcase
          end
        end
      endcase
      if (state == ST_IDLE && !i_line)
        o_par_err <= 1'b0;
    end
  end
endmodule : ufc_rx
`default_nettype wire

// File: ufc_checker.sv
`timescale 1ns/10ps
`default_nettype none
module ufc_checker
  import ufc_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_arst_n,
  input wire logic [ufc_pkg::ADDR_W-1:0] i_s_axi_awaddr,
  input wire logic i_s_axi_awvalid,
  input wire logic o_s_axi_awready,
  input wire logic [31:0] i_s_axi_wdata,
  input wire logic [3:0] i_s_axi_wstrb,
  input wire logic [1:0] o_s_axi_bresp,
  input wire logic o_s_axi_bvalid,
  input wire logic i_s_axi_bready,
  input wire logic [ufc_pkg::ADDR_W-1:0] i_s_axi_araddr,
  input wire logic i_s_axi_arvalid,
  input wire logic o_s_axi_arready,
  input wire logic [31:0] o_s_axi_rdata,
  input wire logic [1:0] o_s_axi_rresp,
  input wire logic o_s_axi_rvalid,
  input wire logic i_s_axi_rready,
  input wire logic o_txd
);
  // ***************************************************************
  // shadow of format and divisor as written over the bus
  // ***************************************************************
  logic [7:0] fmt;
  logic div0;
  logic aw_map;
  logic ar_map;
  always_comb aw_map = i_s_axi_awaddr[16:2] inside {IDX_FMT, IDX_DIV, IDX_TXD, IDX_RXD, IDX_STAT};
  always_comb ar_map = i_s_axi_araddr[16:2] inside {IDX_FMT, IDX_DIV, IDX_TXD, IDX_RXD, IDX_STAT};
  always_ff @(posedge i_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
      fmt <= FMT_RST;
    else if (o_s_axi_awready && i_s_axi_awaddr[16:2] == IDX_FMT && i_s_axi_wstrb[0])
      fmt <= i_s_axi_wdata[7:0];
  end
  // start-bit timing below only holds with the divisor at zero
  always_ff @(posedge i_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
      div0 <= 1'b0;
    else if (o_s_axi_awready && i_s_axi_awaddr[16:2] == IDX_DIV && i_s_axi_wstrb[1:0] == 2'h3)
      div0 <= (i_s_axi_wdata[15:0] == 16'h0000);
  end

  // ***************************************************************
  // properties
  // ***************************************************************
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_arst_n);
  sequence s_wr;
    i_s_axi_awvalid && o_s_axi_awready;
  endsequence
  sequence s_rd;
    i_s_axi_arvalid && o_s_axi_arready;
  endsequence
  property p_wr_answer;
    s_wr |=> o_s_axi_bvalid && o_s_axi_bresp == ($past(aw_map) ? RESP_OKAY : RESP_SLVERR);
  endproperty
  a_wr_answer: assert property (p_wr_answer) else $error("write answer wrong");
  property p_rd_answer;
    s_rd |=> o_s_axi_rvalid && o_s_axi_rresp == ($past(ar_map) ? RESP_OKAY : RESP_SLVERR);
  endproperty
  a_rd_answer: assert property (p_rd_answer) else $error("read answer wrong");
  property p_b_hold;
    o_s_axi_bvalid && !i_s_axi_bready |=> o_s_axi_bvalid && $stable(o_s_axi_bresp);
  endproperty
  a_b_hold: assert property (p_b_hold) else $error("write response dropped");
  property p_r_hold;
    o_s_axi_rvalid && !i_s_axi_rready |=> o_s_axi_rvalid && $stable(o_s_axi_rdata);
  endproperty
  a_r_hold: assert property (p_r_hold) else $error("read response dropped");
  property p_fmt_read;
    s_rd ##0 (i_s_axi_araddr[16:2] == IDX_FMT) |=> o_s_axi_rdata == {24'h0, $past(fmt)};
  endproperty
  a_fmt_read: assert property (p_fmt_read) else $error("format readback wrong");
  property p_unmapped_zero;
    s_rd ##0 !ar_map |=> o_s_axi_rdata == 32'h0;
  endproperty
  a_unmapped_zero: assert property (p_unmapped_zero) else $error("unmapped read not zero");
  property p_loop_quiet;
    fmt[FMT_LOOP] && $past(fmt[FMT_LOOP]) |-> o_txd;
  endproperty
  a_loop_quiet: assert property (p_loop_quiet) else $error("line active in loopback");
  property p_start_bit;
    $fell(o_txd) && div0 |-> (!o_txd) [*8];
  endproperty
  a_start_bit: assert property (p_start_bit) else $error("start bit too short");
endmodule : ufc_checker

bind ufc_top ufc_checker u_chk (.i_clk(i_clk), .i_arst_n(i_arst_n),
  .i_s_axi_awaddr(i_s_axi_awaddr), .i_s_axi_awvalid(i_s_axi_awvalid),
  .o_s_axi_awready(o_s_axi_awready), .i_s_axi_wdata(i_s_axi_wdata),
  .i_s_axi_wstrb(i_s_axi_wstrb), .o_s_axi_bresp(o_s_axi_bresp), .o_s_axi_bvalid(o_s_axi_bvalid),
  .i_s_axi_bready(i_s_axi_bready), .i_s_axi_araddr(i_s_axi_araddr),
  .i_s_axi_arvalid(i_s_axi_arvalid), .o_s_axi_arready(o_s_axi_arready),
  .o_s_axi_rdata(o_s_axi_rdata), .o_s_axi_rresp(o_s_axi_rresp), .o_s_axi_rvalid(o_s_axi_rvalid),
  .i_s_axi_rready(i_s_axi_rready), .o_txd(o_txd));
`default_nettype wire

// File: ufc_line_model.sv
`timescale 1ns/10ps
`default_nettype none
module ufc_line_model
(
  input wire logic i_clk,
  input wire logic i_line,
  output logic o_line
);
  // ***************************************************************
  // remote serial node, sixteen clocks a bit with the divisor at zero
  // ***************************************************************
  localparam int BIT_CLKS = 16;
  initial o_line = 1'b1;

  // bad parity, bad stop level or a short gap are sent only when asked for
  task automatic send(input logic [7:0] d, input logic a, input logic [7:0] f, input logic par,
                      input int nstop, input logic stop);
    logic q[$];
    q.push_back(1'b0);
    for (int i = 0; i <= int'(f[2:0]); i++)
      q.push_back(d[i]);
    if (f[3])
      q.push_back(a);
    if (f[5])
      q.push_back(par);
    repeat (nstop)
      q.push_back(stop);
    foreach (q[i])
    begin
      o_line <= q[i];
      repeat (BIT_CLKS) @(posedge i_clk);
    end
    o_line <= 1'b1;
    @(posedge i_clk);
  endtask : send

  task automatic bit_at(output logic b);
    repeat (BIT_CLKS) @(posedge i_clk);
    b = i_line;
  endtask : bit_at

  // bits: 7:0 data, 8 address bit, 9 parity, 10 first stop
  task automatic capture(input logic [7:0] f, output logic [10:0] bits);
    int n;
    bits = '0;
    n = 0;
    while (i_line && n < 400)
    begin
      @(posedge i_clk);
      n++;
    end
    repeat (BIT_CLKS / 2) @(posedge i_clk);
    for (int i = 0; i <= int'(f[2:0]); i++)
      bit_at(bits[i]);
    if (f[3])
      bit_at(bits[8]);
    if (f[5])
      bit_at(bits[9]);
    bit_at(bits[10]);
  endtask : capture
endmodule : ufc_line_model
`default_nettype wire

// File: tb.sv
`timescale 1ns/10ps
`default_nettype none
module tb;
  import ufc_pkg::*;
  localparam logic [16:0] A_FMT = {IDX_FMT, 2'b00};
  localparam logic [16:0] A_DIV = {IDX_DIV, 2'b00};
  localparam logic [16:0] A_TXD = {IDX_TXD, 2'b00};
  localparam logic [16:0] A_RXD = {IDX_RXD, 2'b00};
  localparam logic [16:0] A_STAT = {IDX_STAT, 2'b00};
  logic clk, arst_n, awvalid, wvalid, bready, arvalid, rready;
  logic awready, wready, bvalid, arready, rvalid, rxd, txd, a;
  logic [ADDR_W-1:0] awaddr, araddr;
  logic [31:0] wdata, rdata, v, seed;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp;
  logic [7:0] f, d, m;
  logic [10:0] cap;
  int errors, checks_done, cyc, t0, nb;

  ufc_top uut (.i_clk(clk), .i_arst_n(arst_n), .i_s_axi_awaddr(awaddr),
    .i_s_axi_awvalid(awvalid), .o_s_axi_awready(awready), .i_s_axi_wdata(wdata),
    .i_s_axi_wstrb(wstrb), .i_s_axi_wvalid(wvalid), .o_s_axi_wready(wready),
    .o_s_axi_bresp(bresp), .o_s_axi_bvalid(bvalid), .i_s_axi_bready(bready),
    .i_s_axi_araddr(araddr), .i_s_axi_arvalid(arvalid), .o_s_axi_arready(arready),
    .o_s_axi_rdata(rdata), .o_s_axi_rresp(rresp), .o_s_axi_rvalid(rvalid),
    .i_s_axi_rready(rready), .i_rxd(rxd), .o_txd(txd));
  ufc_line_model u_line (.i_clk(clk), .i_line(txd), .o_line(rxd));

  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  initial cyc = 0;
  always @(posedge clk) cyc <= cyc + 1;

  // ***************************************************************
  // helpers
  // ***************************************************************
  function automatic logic [31:0] nxt(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : nxt

  function automatic logic par_of(input logic [7:0] x, input logic [7:0] g, input logic b);
    return ^(x & (8'hff >> (3'h7 - g[2:0]))) ^ (g[3] & b) ^ ~g[6];
  endfunction : par_of

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    checks_done++;
    if (got !== exp)
    begin
      errors++;
      $display("unexpected at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [16:0] ad, input logic [31:0] dt, input logic [3:0] s,
                    input logic [1:0] er);
    awaddr <= ad;
    wdata <= dt;
    wstrb <= s;
    {awvalid, wvalid} <= 2'b11;
    do @(posedge clk); while (!awready);
    chk(wready, 1'b1, "wready");
    {awvalid, wvalid} <= 2'b00;
    @(posedge clk);
    bready <= 1'b1;
    do @(posedge clk); while (!bvalid);
    bready <= 1'b0;
    chk(bresp, er, "bresp");
  endtask : wr

  task automatic rd(input logic [16:0] ad, output logic [31:0] dt, input logic [1:0] er);
    araddr <= ad;
    arvalid <= 1'b1;
    do @(posedge clk); while (!arready);
    arvalid <= 1'b0;
    @(posedge clk);
    rready <= 1'b1;
    do @(posedge clk); while (!rvalid);
    rready <= 1'b0;
    dt = rdata;
    chk(rresp, er, "rresp");
  endtask : rd

  task automatic end_sim();
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : end_sim

  initial
  begin
    repeat (40000) @(posedge clk);
    errors++;
    end_sim();
  end

  // ***************************************************************
  // scenarios
  // ***************************************************************
  initial
  begin
    {awvalid, wvalid, bready, arvalid, rready} = '0;
    {awaddr, araddr, wdata, wstrb} = '0;
    arst_n = 1'b0;
    errors = 0;
    checks_done = 0;
    seed = 32'he154;
    repeat (8) @(posedge clk);
    arst_n <= 1'b1;
    @(posedge clk);
    rd(A_FMT, v, RESP_OKAY);
    chk(v, 32'h0, "format reset");
    wr(A_DIV, 32'h0, 4'hf, RESP_OKAY);
    f = 8'h00;
    for (int i = 0; i < 6; i++)
    begin
      seed = nxt(seed);
      // the last pass writes with no strobe, so the value must not move
      wr(A_FMT, seed, {3'h0, i != 5}, RESP_OKAY);
      if (i != 5)
        f = seed[7:0];
      rd(A_FMT, v, RESP_OKAY);
      chk(v, {24'h0, f}, "format rw");
    end
    wr(17'h00010, seed, 4'hf, RESP_SLVERR);
    rd(17'h00010, v, RESP_SLVERR);
    // transmit every length, both stop counts, both polarities
    for (int l = 0; l < 8; l++)
    begin
      seed = nxt(seed);
      f = {l[0], l[1], ~l[0] | seed[5], 1'b0, l[2] ^ seed[3], l[2:0]};
      d = seed[23:16];
      a = seed[8];
      m = 8'hff >> (7 - l);
      nb = 3 + l + f[3] + f[5] + f[7];
      wr(A_FMT, {24'h0, f}, 4'h1, RESP_OKAY);
      fork
        u_line.capture(f, cap);
        begin
          t0 = cyc;
          wr(A_TXD, {23'h0, a, d}, 4'h3, RESP_OKAY);
          do rd(A_STAT, v, RESP_OKAY); while (v[ST_TX_BUSY] === 1'b1);
        end
      join
      chk(cap, {1'b1, f[5] & par_of(d, f, a), f[3] & a, d & m}, "tx frame");
      chk(32'(cyc - t0 >= nb * 16 && cyc - t0 <= nb * 16 + 10), 32'h1, "tx time");
    end
    // receive every length; 4 bad parity, 5 bad stop, 6 frames with one stop
    for (int l = 0; l < 8; l++)
    begin
      seed = nxt(seed);
      f = {l[1], l[0], ~l[1], 1'b0, seed[3], l[2:0]};
      d = seed[23:16];
      a = seed[8];
      m = 8'hff >> (7 - l);
      wr(A_FMT, {24'h0, f}, 4'h1, RESP_OKAY);
      wr(A_STAT, 32'hc, 4'h1, RESP_OKAY);
      if (l == 6)
        u_line.send(~d, a, f, par_of(~d, f, a), 1, 1'b1);
      u_line.send(d, a, f, par_of(d, f, a) ^ (l == 4), l == 6 ? 1 : f[7] + 1, l != 5);
      rd(A_STAT, v, RESP_OKAY);
      chk(v, {28'h0, l == 5, l == 4, 2'b10}, "rx status");
      rd(A_RXD, v, RESP_OKAY);
      if (l != 5)
        chk(v, {23'h0, f[3] & a, d & m}, "rx data");
    end
    // loopback: frame returns internally while the pin stays idle
    seed = nxt(seed);
    d = seed[7:0];
    wr(A_FMT, 32'h37, 4'h1, RESP_OKAY);
    wr(A_TXD, {24'h0, d}, 4'h3, RESP_OKAY);
    do rd(A_STAT, v, RESP_OKAY); while (v[ST_TX_BUSY] === 1'b1);
    rd(A_STAT, v, RESP_OKAY);
    chk(v, 32'h2, "loopback status");
    rd(A_RXD, v, RESP_OKAY);
    chk(v, {24'h0, d}, "loopback data");
    wr(A_FMT, 32'h07, 4'h1, RESP_OKAY);
    end_sim();
  end
endmodule : tb
`default_nettype wire
